// ---- include/tpo_pkg.sv ----
// Package for the tributary path overhead monitor register block.
// Holds register indices, field positions, timing counts and the carrier types.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
package tpo_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_AIS_CTRL = 10'h010;  // Global alarm AIS control.
    localparam logic [9:0] IDX_CONFIG = 10'h108;  // Counting mode for the tributary.
    localparam logic [9:0] IDX_CFG_ALARM = 10'h109;  // Defect source, termination, status.
    localparam logic [9:0] IDX_EXPECTED = 10'h10a;  // expected_label_tug2_2.
    localparam logic [9:0] IDX_ACCEPTED = 10'h10b;  // accepted_label_tug2_2.
    localparam logic [9:0] IDX_PAR_LOW = 10'h10c;  // parity_count_low_tug2_2.
    localparam logic [9:0] IDX_PAR_HIGH = 10'h10d;  // parity_count_high_tug2_2.
    localparam logic [9:0] IDX_FAR_LOW = 10'h10e;  // far_end_count_low_tug2_2.
    localparam logic [9:0] IDX_FAR_HIGH = 10'h10f;  // far_end_count_high_tug2_2.
    localparam logic [9:0] IDX_PENDING = 10'h138;  // label_change_pending.
    localparam logic [9:0] IDX_TRIGGER = 10'h13e;  // Accumulate trigger, write only.
    localparam logic [9:0] IDX_IRQ_EN = 10'h13f;  // Per-tributary label change enables.

    // ------------------------------------------------------------------
    // Field positions, tributary numbers, acceptance count and response codes.
    // ------------------------------------------------------------------
    localparam int BIT_BLOCK_MODE = 5;  // In the configuration register.
    localparam int BIT_EXT_SEL = 7;  // In the configuration and alarm register.
    localparam int BIT_TERM_EN = 6;  // In the configuration and alarm register.
    localparam int BIT_MISMATCH = 3;  // In the configuration and alarm register.
    localparam int MON_TRIB = 1;  // Tributary served by the mapped label and counters.
    localparam int NUM_TRIB = 7;  // Tributaries in the pending register.
    localparam logic [2:0] LABEL_ACCEPT_COUNT = 3'h5;  // Consecutive multiframes to accept.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Timing: the counter snapshot must land within this bound.
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int SNAPSHOT_MAX_US = 10;
    localparam int SNAPSHOT_MAX_CYC = SNAPSHOT_MAX_US * CLK_MHZ;  // Longest time, rounded down.

    // ------------------------------------------------------------------
    // Carrier types.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } tpo_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tpo_axi_rsp_t;

    // All state of the block in one record.
    typedef struct packed {
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] expected;
        logic [2:0] ais_ctrl;
        logic block_mode;
        logic ext_sel;
        logic term_en;
        logic [6:0] irq_en;
        logic [6:0][2:0] cand;
        logic [6:0][2:0] cnt;
        logic [6:0][2:0] accepted;
        logic [6:0] pending;
        logic [2:0] defect;
        logic mismatch;
        logic ais;
        logic [10:0] bip_acc;
        logic [10:0] bip_cnt;
        logic [10:0] febe_acc;
        logic [10:0] febe_cnt;
    } tpo_state_t;

endpackage

// ---- rtl/tpo_monitor_regs.sv ----
// Register bank and per-tributary monitors for the tributary path overhead.
// Assumes overhead inputs synchronous to clk_sys and an AXI4-Lite master.
//
// How it works
// - Terminated tributary inserts AIS per global control.
// - Through tributary inserts AIS only on pointer/multiframe loss.
// - Select low: defect bits from V5 RDI/RFI.
// - Select high: defect field from Z7 extended code.
// - Writable expected label, reset zero, compared.
// - Accept label after five identical multiframes.
// - Mismatch set when accepted differs from expected.
// - Label and counter registers inert in TU3 mode.
// - Parity count eleven bits, split, wraps freely.
// - Trigger write snapshots parity count, restarts accumulator.
// - Parity counting per bit or per block.
// - Block mode adds one; bit mode adds per bit.
// - Far-end count eleven bits, snapshot on trigger.
// - Bit zero is TU3 stream or first tributary.
// - In TU3 mode bits one to six read zero.
// - Accepted label change sets pending bit.
// - Reading pending register clears all pending bits.
// - Pending bits set regardless of interrupt enable.
// - Interrupt raised only when tributary enable set.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tpo_monitor_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire tpo_pkg::tpo_axi_req_t axi_req,
    output tpo_pkg::tpo_axi_rsp_t axi_rsp,
    input wire logic tu3_mode,
    input wire logic [6:0] label_strobe,
    input wire logic [6:0][2:0] rx_label,
    input wire logic v5_rdi,
    input wire logic v5_rfi,
    input wire logic [2:0] z7_code,
    input wire logic pointer_loss,
    input wire logic multiframe_loss,
    input wire logic bip_valid,
    input wire logic [1:0] bip_err,
    input wire logic far_end_error,
    output logic ais_insert,
    output logic label_mismatch_state,
    output logic [2:0] defect_status,
    output logic irq
);

    // ------------------------------------------------------------------
    // State and combinational helpers.
    // ------------------------------------------------------------------
    tpo_pkg::tpo_state_t s_ff;  // Registered state of the whole block.
    tpo_pkg::tpo_state_t nxt_s;  // Next state.
    logic aw_take;  // Write address accepted this cycle.
    logic w_take;  // Write data accepted this cycle.
    logic ar_take;  // Read address accepted this cycle.
    logic wr_fire;  // Register write carried out this cycle.
    logic [9:0] wr_idx;  // Index of the pending write.
    logic [9:0] rd_idx;  // Index of the read being taken.
    logic trig;  // Accumulate trigger write this cycle.
    logic [10:0] bip_inc;  // Parity errors seen this cycle.
    logic [10:0] febe_inc;  // Far-end errors seen this cycle.
    logic [6:0] pend_set;  // Label change events this cycle.
    logic [6:0] pend_clr;  // Pending bits cleared by a read.
    logic [6:0] pend_vis;  // Pending bits as software sees them.

    // Ready outputs are combinational; valid, response and data come from flip-flops.
    assign axi_rsp.awready = !s_ff.aw_got && !s_ff.bvalid;
    assign axi_rsp.wready = !s_ff.w_got && !s_ff.bvalid;
    assign axi_rsp.arready = !s_ff.rvalid;
    assign axi_rsp.bvalid = s_ff.bvalid;
    assign axi_rsp.bresp = s_ff.bresp;
    assign axi_rsp.rvalid = s_ff.rvalid;
    assign axi_rsp.rdata = s_ff.rdata;
    assign axi_rsp.rresp = s_ff.rresp;
    assign aw_take = axi_req.awvalid && axi_rsp.awready;
    assign w_take = axi_req.wvalid && axi_rsp.wready;
    assign ar_take = axi_req.arvalid && axi_rsp.arready;
    assign wr_fire = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    assign wr_idx = s_ff.awaddr[11:2];
    assign rd_idx = axi_req.araddr[11:2];
    assign trig = wr_fire && (wr_idx == tpo_pkg::IDX_TRIGGER);

    // In TU3 mode the upper pending bits are unused and read as zero.
    assign pend_vis = tu3_mode ? {6'h00, s_ff.pending[0]} : s_ff.pending;

    // Status outputs straight from state.
    assign ais_insert = s_ff.ais;
    assign label_mismatch_state = s_ff.mismatch;
    assign defect_status = s_ff.defect;
    // Enable gates only the interrupt, never the pending bit itself.
    assign irq = |(pend_vis & s_ff.irq_en);

    // ------------------------------------------------------------------
    // Error increments for the monitored tributary.
    // ------------------------------------------------------------------
    always_comb begin
        bip_inc = 11'h000;
        febe_inc = 11'h000;
        if (bip_valid && !tu3_mode) begin
            if (s_ff.block_mode) begin
                bip_inc = {10'h000, |bip_err};
            end else begin
                bip_inc = {10'h000, bip_err[0]} + {10'h000, bip_err[1]};
            end
        end
        if (far_end_error && !tu3_mode) begin
            febe_inc = 11'h001;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic for bus, labels, counters and alarms.
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        pend_set = 7'h00;
        pend_clr = 7'h00;

        // Write address and data are taken in either order.
        if (aw_take) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = axi_req.awaddr;
        end
        if (w_take) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = axi_req.wdata;
            nxt_s.wstrb = axi_req.wstrb;
        end
        if (s_ff.bvalid && axi_req.bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // Carry out the write once both halves are held.
        if (wr_fire) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = tpo_pkg::RESP_OKAY;
            if (wr_idx == tpo_pkg::IDX_AIS_CTRL) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.ais_ctrl = s_ff.wdata[2:0];
                end
            end else if (wr_idx == tpo_pkg::IDX_CONFIG) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.block_mode = s_ff.wdata[tpo_pkg::BIT_BLOCK_MODE];
                end
            end else if (wr_idx == tpo_pkg::IDX_CFG_ALARM) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.ext_sel = s_ff.wdata[tpo_pkg::BIT_EXT_SEL];
                    nxt_s.term_en = s_ff.wdata[tpo_pkg::BIT_TERM_EN];
                end
            end else if (wr_idx == tpo_pkg::IDX_EXPECTED) begin
                // The expected label is frozen while the stream is TU3.
                if (s_ff.wstrb[0] && !tu3_mode) begin
                    nxt_s.expected = s_ff.wdata[2:0];
                end
            end else if (wr_idx == tpo_pkg::IDX_IRQ_EN) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.irq_en = s_ff.wdata[6:0];
                end
            end else if (wr_idx == tpo_pkg::IDX_TRIGGER || wr_idx == tpo_pkg::IDX_PENDING ||
                         (wr_idx >= tpo_pkg::IDX_ACCEPTED && wr_idx <= tpo_pkg::IDX_FAR_HIGH)) begin
                // Read-only and trigger locations accept and drop the data.
                nxt_s.bresp = tpo_pkg::RESP_OKAY;
            end else begin
                nxt_s.bresp = tpo_pkg::RESP_SLVERR;
            end
        end

        // Read channel: one read in flight; data held until taken.
        if (s_ff.rvalid && axi_req.rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (ar_take) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = tpo_pkg::RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
            if (rd_idx == tpo_pkg::IDX_AIS_CTRL) begin
                nxt_s.rdata[2:0] = s_ff.ais_ctrl;
            end else if (rd_idx == tpo_pkg::IDX_CONFIG) begin
                nxt_s.rdata[tpo_pkg::BIT_BLOCK_MODE] = s_ff.block_mode;
            end else if (rd_idx == tpo_pkg::IDX_CFG_ALARM) begin
                nxt_s.rdata[tpo_pkg::BIT_EXT_SEL] = s_ff.ext_sel;
                nxt_s.rdata[tpo_pkg::BIT_TERM_EN] = s_ff.term_en;
                nxt_s.rdata[tpo_pkg::BIT_MISMATCH] = s_ff.mismatch;
                nxt_s.rdata[2:0] = s_ff.defect;
            end else if (rd_idx == tpo_pkg::IDX_EXPECTED) begin
                nxt_s.rdata[2:0] = s_ff.expected;
            end else if (rd_idx == tpo_pkg::IDX_ACCEPTED) begin
                nxt_s.rdata[2:0] = s_ff.accepted[tpo_pkg::MON_TRIB];
            end else if (rd_idx == tpo_pkg::IDX_PAR_LOW) begin
                nxt_s.rdata[7:0] = s_ff.bip_cnt[7:0];
            end else if (rd_idx == tpo_pkg::IDX_PAR_HIGH) begin
                nxt_s.rdata[2:0] = s_ff.bip_cnt[10:8];
            end else if (rd_idx == tpo_pkg::IDX_FAR_LOW) begin
                nxt_s.rdata[7:0] = s_ff.febe_cnt[7:0];
            end else if (rd_idx == tpo_pkg::IDX_FAR_HIGH) begin
                nxt_s.rdata[2:0] = s_ff.febe_cnt[10:8];
            end else if (rd_idx == tpo_pkg::IDX_PENDING) begin
                // Bit 7 is reserved and reads zero; the read acknowledges everything.
                nxt_s.rdata[6:0] = pend_vis;
                pend_clr = 7'h7f;
            end else if (rd_idx == tpo_pkg::IDX_IRQ_EN) begin
                nxt_s.rdata[6:0] = s_ff.irq_en;
            end else if (rd_idx == tpo_pkg::IDX_TRIGGER) begin
                nxt_s.rdata = 32'h0000_0000;
            end else begin
                nxt_s.rresp = tpo_pkg::RESP_SLVERR;
            end
        end

        // Label acceptance per tributary; only the TU3 stream runs in TU3 mode.
        for (int t = 0; t < tpo_pkg::NUM_TRIB; t++) begin
            if (label_strobe[t] && (!tu3_mode || t == 0)) begin
                if (rx_label[t] != s_ff.cand[t]) begin
                    nxt_s.cand[t] = rx_label[t];
                    nxt_s.cnt[t] = 3'h1;
                end else if (s_ff.cnt[t] < tpo_pkg::LABEL_ACCEPT_COUNT) begin
                    nxt_s.cnt[t] = s_ff.cnt[t] + 3'h1;
                    if (s_ff.cnt[t] + 3'h1 == tpo_pkg::LABEL_ACCEPT_COUNT) begin
                        nxt_s.accepted[t] = s_ff.cand[t];
                        // A change sets pending whatever the enable says.
                        pend_set[t] = (s_ff.accepted[t] != s_ff.cand[t]);
                    end
                end
            end
        end
        // A new event wins over a clear in the same cycle.
        nxt_s.pending = (s_ff.pending & ~pend_clr) | pend_set;

        // Mismatch of the monitored tributary; inert in TU3 mode.
        if (tu3_mode) begin
            nxt_s.mismatch = 1'b0;
        end else begin
            nxt_s.mismatch = (s_ff.accepted[tpo_pkg::MON_TRIB] != s_ff.expected);
        end

        // Remote defect status sampled once per multiframe.
        if (label_strobe[tpo_pkg::MON_TRIB]) begin
            if (s_ff.ext_sel) begin
                nxt_s.defect = z7_code;
            end else begin
                nxt_s.defect = {1'b0, v5_rfi, v5_rdi};
            end
        end

        // AIS: terminated paths follow every enabled cause, through paths only losses.
        if (s_ff.term_en) begin
            nxt_s.ais = |({s_ff.mismatch, multiframe_loss, pointer_loss} & s_ff.ais_ctrl);
        end else begin
            nxt_s.ais = |({multiframe_loss, pointer_loss} & s_ff.ais_ctrl[1:0]);
        end

        // Counters wrap instead of saturating; a trigger snapshots and restarts.
        // An error in the trigger cycle opens the new interval so none is lost.
        if (trig) begin
            nxt_s.bip_cnt = s_ff.bip_acc;
            nxt_s.bip_acc = bip_inc;
            nxt_s.febe_cnt = s_ff.febe_acc;
            nxt_s.febe_acc = febe_inc;
        end else begin
            nxt_s.bip_acc = s_ff.bip_acc + bip_inc;
            nxt_s.febe_acc = s_ff.febe_acc + febe_inc;
        end
    end

    // ------------------------------------------------------------------
    // State register; synchronous reset clears everything to zero.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_pend_set;
        (!tu3_mode && label_strobe[1] && rx_label[1] == s_ff.cand[1] && s_ff.cnt[1] == 3'h4 &&
         s_ff.accepted[1] != s_ff.cand[1]) |=> s_ff.pending[1];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("label change did not set pending");

    property p_accept;
        (!tu3_mode && label_strobe[1] && rx_label[1] == s_ff.cand[1] && s_ff.cnt[1] == 3'h4)
            |=> s_ff.accepted[1] == $past(s_ff.cand[1]);
    endproperty
    a_accept: assert property (p_accept) else $error("label not accepted on fifth multiframe");

    property p_read_clear;
        (ar_take && rd_idx == tpo_pkg::IDX_PENDING && label_strobe == 7'h00) |=> s_ff.pending == 7'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("pending not cleared by read");

    property p_irq;
        (!tu3_mode && s_ff.pending[1] && s_ff.irq_en[1]) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled pending bit gave no interrupt");

    property p_tu3_zero;
        (ar_take && rd_idx == tpo_pkg::IDX_PENDING && tu3_mode) |=> s_ff.rvalid && s_ff.rdata[7:1] == 7'h00;
    endproperty
    a_tu3_zero: assert property (p_tu3_zero) else $error("upper pending bits not zero in TU3 mode");

    property p_bip_snap;
        trig |=> (s_ff.bip_cnt == $past(s_ff.bip_acc)) && (s_ff.bip_acc == $past(bip_inc));
    endproperty
    a_bip_snap: assert property (p_bip_snap) else $error("parity snapshot wrong");

    property p_febe_snap;
        trig |=> (s_ff.febe_cnt == $past(s_ff.febe_acc)) && (s_ff.febe_acc == $past(febe_inc));
    endproperty
    a_febe_snap: assert property (p_febe_snap) else $error("far-end snapshot wrong");

    property p_block;
        (!trig && !tu3_mode && bip_valid && bip_err == 2'h3 && s_ff.block_mode)
            |=> s_ff.bip_acc == $past(s_ff.bip_acc) + 11'h001;
    endproperty
    a_block: assert property (p_block) else $error("block mode added wrong amount");

    property p_mismatch;
        !tu3_mode |=> s_ff.mismatch == ($past(s_ff.accepted[1]) != $past(s_ff.expected));
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch state wrong");

    property p_through;
        (!s_ff.term_en && !pointer_loss && !multiframe_loss) |=> !s_ff.ais;
    endproperty
    a_through: assert property (p_through) else $error("through path AIS without loss");

    c_write: cover property (wr_fire ##[1:4] s_ff.bvalid && axi_req.bready);
    c_change: cover property (pend_set[1] ##[1:20] (ar_take && rd_idx == tpo_pkg::IDX_PENDING));
    c_snap: cover property (trig ##1 s_ff.bip_cnt != 11'h000);

endmodule

`default_nettype wire

// ---- verif/tributary_path_overhead_monitor_regs_bench.sv ----
// Self-checking bench for the tributary overhead monitor register block.
// Assumes the package is compiled first and that the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module tributary_path_overhead_monitor_regs_bench;
    logic clk_sys;
    logic sys_rst;
    logic tu3_mode, v5_rdi, v5_rfi, pointer_loss, multiframe_loss, bip_valid, far_end_error;
    logic [6:0] label_strobe;
    logic [6:0][2:0] rx_label;
    logic [2:0] z7_code;
    logic [1:0] bip_err;
    logic ais_insert, label_mismatch_state, irq;
    logic [2:0] defect_status;
    tpo_pkg::tpo_axi_req_t req;
    tpo_pkg::tpo_axi_rsp_t rsp;
    int bad_count = 0;
    int check_count = 0;

    tpo_monitor_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp),
        .tu3_mode(tu3_mode), .label_strobe(label_strobe), .rx_label(rx_label), .v5_rdi(v5_rdi),
        .v5_rfi(v5_rfi), .z7_code(z7_code), .pointer_loss(pointer_loss), .multiframe_loss(multiframe_loss),
        .bip_valid(bip_valid), .bip_err(bip_err), .far_end_error(far_end_error), .ais_insert(ais_insert),
        .label_mismatch_state(label_mismatch_state), .defect_status(defect_status), .irq(irq));

    // 20 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Shared tasks: comparison, verdict, bus cycles and stream stimulus.
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One write; address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] resp = tpo_pkg::RESP_OKAY);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                req.bready <= 1'b0;
                check({30'h0, rsp.bresp}, {30'h0, resp});
                break;
            end
        end
        // Two spare edges let registered status outputs follow the new setting.
        repeat (2) @(posedge clk_sys);
    endtask

    // One read, judged against the expected data and response.
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] resp);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                req.rready <= 1'b0;
                check(rsp.rdata, exp);
                check({30'h0, rsp.rresp}, {30'h0, resp});
                break;
            end
        end
        @(posedge clk_sys);
    endtask

    // Presents k multiframes of label v on tributary t, one strobe every second cycle.
    task automatic lab(input int t, input logic [2:0] v, input int k);
        repeat (k) begin
            @(posedge clk_sys);
            label_strobe[t] <= 1'b1;
            rx_label[t] <= v;
            @(posedge clk_sys);
            label_strobe[t] <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
    endtask

    // Each pulse carries parity error bits e and one far-end block error.
    task automatic par(input logic [1:0] e, input int k);
        repeat (k) begin
            @(posedge clk_sys);
            bip_valid <= 1'b1;
            bip_err <= e;
            far_end_error <= 1'b1;
            @(posedge clk_sys);
            bip_valid <= 1'b0;
            far_end_error <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_label;
        rd(tpo_pkg::IDX_EXPECTED, 32'h0, tpo_pkg::RESP_OKAY);
        rd(10'h001, 32'h0, tpo_pkg::RESP_SLVERR);
        wr(10'h001, 8'h00, tpo_pkg::RESP_SLVERR);
        wr(tpo_pkg::IDX_EXPECTED, 8'hfd);
        rd(tpo_pkg::IDX_EXPECTED, 32'h5, tpo_pkg::RESP_OKAY);
        check({31'h0, label_mismatch_state}, 32'h1);
        lab(1, 3'h5, 4);
        rd(tpo_pkg::IDX_ACCEPTED, 32'h0, tpo_pkg::RESP_OKAY);
        lab(1, 3'h5, 1);
        rd(tpo_pkg::IDX_ACCEPTED, 32'h5, tpo_pkg::RESP_OKAY);
        check({31'h0, label_mismatch_state}, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(tpo_pkg::IDX_IRQ_EN, 8'h02);
        check({31'h0, irq}, 32'h1);
        wr(tpo_pkg::IDX_PENDING, 8'h00);
        rd(tpo_pkg::IDX_PENDING, 32'h2, tpo_pkg::RESP_OKAY);
        rd(tpo_pkg::IDX_PENDING, 32'h0, tpo_pkg::RESP_OKAY);
        check({31'h0, irq}, 32'h0);
    endtask

    // 260 bit errors cross the byte boundary; block mode then proves the restart.
    task automatic t_count;
        par(2'b11, 130);
        wr(tpo_pkg::IDX_TRIGGER, 8'h00);
        rd(tpo_pkg::IDX_PAR_LOW, 32'h04, tpo_pkg::RESP_OKAY);
        rd(tpo_pkg::IDX_PAR_HIGH, 32'h01, tpo_pkg::RESP_OKAY);
        rd(tpo_pkg::IDX_FAR_LOW, 32'h82, tpo_pkg::RESP_OKAY);
        wr(tpo_pkg::IDX_CONFIG, 8'h20);
        par(2'b01, 2);
        par(2'b11, 1);
        wr(tpo_pkg::IDX_TRIGGER, 8'h00);
        rd(tpo_pkg::IDX_PAR_LOW, 32'h03, tpo_pkg::RESP_OKAY);
        rd(tpo_pkg::IDX_FAR_LOW, 32'h03, tpo_pkg::RESP_OKAY);
    endtask

    task automatic t_alarm;
        v5_rdi <= 1'b1;
        v5_rfi <= 1'b1;
        lab(1, 3'h5, 1);
        check({29'h0, defect_status}, 32'h3);
        wr(tpo_pkg::IDX_CFG_ALARM, 8'h80);
        z7_code <= 3'h6;
        lab(1, 3'h5, 1);
        check({29'h0, defect_status}, 32'h6);
        wr(tpo_pkg::IDX_AIS_CTRL, 8'h04);
        wr(tpo_pkg::IDX_EXPECTED, 8'h03);
        rd(tpo_pkg::IDX_CFG_ALARM, 32'h8e, tpo_pkg::RESP_OKAY);
        check({31'h0, ais_insert}, 32'h0);
        wr(tpo_pkg::IDX_CFG_ALARM, 8'h40);
        check({31'h0, ais_insert}, 32'h1);
        wr(tpo_pkg::IDX_CFG_ALARM, 8'h00);
        wr(tpo_pkg::IDX_AIS_CTRL, 8'h01);
        pointer_loss <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, ais_insert}, 32'h1);
        pointer_loss <= 1'b0;
        multiframe_loss <= 1'b1;
        wr(tpo_pkg::IDX_AIS_CTRL, 8'h02);
        check({31'h0, ais_insert}, 32'h1);
    endtask

    task automatic t_tu3;
        lab(2, 3'h4, 5);
        tu3_mode <= 1'b1;
        rd(tpo_pkg::IDX_PENDING, 32'h0, tpo_pkg::RESP_OKAY);
        wr(tpo_pkg::IDX_EXPECTED, 8'h01);
        rd(tpo_pkg::IDX_EXPECTED, 32'h3, tpo_pkg::RESP_OKAY);
        lab(0, 3'h2, 5);
        rd(tpo_pkg::IDX_PENDING, 32'h1, tpo_pkg::RESP_OKAY);
    endtask

    // Main sequence: every input is given a value at time zero, then reset for five cycles.
    initial begin
        req = '0;
        {tu3_mode, v5_rdi, v5_rfi, pointer_loss, multiframe_loss, bip_valid, far_end_error} = 7'h0;
        label_strobe = 7'h0;
        rx_label = '0;
        z7_code = 3'h0;
        bip_err = 2'h0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_label;
        t_count;
        t_alarm;
        t_tu3;
        finish_test;
    end

    // Watchdog; the whole sequence needs well under a tenth of this span.
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        finish_test;
    end
endmodule
`default_nettype wire
